// >>> common/addr_decode_pkg.sv
// package: address map constants, target encodings and carrier structs for the decoder
package addr_decode_pkg;

    // ==========================================================
    // default window bounds
    // ==========================================================
    localparam logic [31:0] IO_BASE      = 32'h8000_0000;  // pci/isa i/o window start
    localparam logic [31:0] IO_LAST      = 32'h8001_ffff;  // 128KB window end
    localparam logic [31:0] MEMC_BASE    = 32'hfef8_0000;  // memory controller registers
    localparam logic [31:0] MEMC_LAST    = 32'hfef8_ffff;
    localparam logic [31:0] BRIDGE_BASE  = 32'hfeff_0000;  // host bridge registers
    localparam logic [31:0] BRIDGE_LAST  = 32'hfeff_ffff;
    localparam logic [31:0] ROM_BASE     = 32'hfff0_0000;  // top 1MB boot window
    localparam logic [31:0] ROM_LAST     = 32'hffff_ffff;
    localparam logic [31:0] ROM_OFF_MASK = 32'h000f_ffff;  // offset inside the 1MB window

    // ==========================================================
    // programmable decoders
    // ==========================================================
    localparam int          NUM_WIN      = 4;              // decoders per direction
    localparam logic [1:0]  DIR_CPU2PCI  = 2'h0;           // processor/dram to pci
    localparam logic [1:0]  DIR_PCI2CPU  = 2'h1;           // pci to processor/dram

    // ==========================================================
    // bus figures
    // ==========================================================
    localparam int          CPU_BUS_MHZ  = 66;             // highest processor bus clock
    localparam int          PCI_BUS_MHZ  = 33;             // highest pci clock
    localparam logic [1:0]  PCI_CMD_DAC  = 2'h3;           // dual address cycle code

    // target encoding, binary codes written out
    typedef enum logic [2:0] {
        TGT_NONE   = 3'b000,
        TGT_PCI_IO = 3'b001,
        TGT_MEMC   = 3'b010,
        TGT_BRIDGE = 3'b011,
        TGT_ROM_A  = 3'b100,
        TGT_ROM_B  = 3'b101,
        TGT_PCI    = 3'b110,
        TGT_CPU    = 3'b111
    } target_t;

    // one programmable window: base, last, translation offset
    typedef struct packed {
        logic        enable;
        logic [31:0] base;
        logic [31:0] last;
        logic [31:0] offset;
    } map_win_t;

    // one request from a bus master
    typedef struct packed {
        logic        valid;
        logic [31:0] addr;
        logic [1:0]  cmd;      // PCI_CMD_DAC is refused
    } bus_req_t;

    // decoded answer
    typedef struct packed {
        logic        valid;
        target_t     target;
        logic [31:0] addr;     // translated, window-relative or unchanged address
    } bus_sel_t;

endpackage

// >>> tb/cpu_master.sv
// partner model: processor bus master issuing one request per cycle
`timescale 1ns/1ps
module cpu_master
    import addr_decode_pkg::*;
(
    // clock
    input  wire logic        clk,
    // request and write data
    output bus_req_t         req,
    output logic      [63:0] wdata,
    output logic      [7:0]  wpar
);
    initial begin
        req   = '0;
        wdata = '0;
        wpar  = '0;
    end
    // request launched after the falling edge, held a whole cycle
    task automatic issue(input logic [31:0] a, input logic [1:0] c,
                         input logic [63:0] d, input logic bad);
        @(negedge clk);
        req   = {1'b1, a, c};
        wdata = d;
        // even lane parity, spoilt on demand
        for (int i = 0; i < 8; i++)
            wpar[i] = ^d[8*i+:8] ^ bad;
    endtask
    // released lines show the inverse, so a stale value never matches
    task automatic idle();
        @(negedge clk);
        req   = {1'b0, ~req.addr, 2'h0};
        wdata = ~wdata;
    endtask
endmodule

// >>> tb/default_addr_decoder_properties.sv
// checker: timing and routing relations at the decoder's ports
`timescale 1ns/1ps
module default_addr_decoder_properties
    import addr_decode_pkg::*;
(
    // clock and reset
    input wire logic        clk,
    input wire logic        rst,
    // requests and data
    input wire bus_req_t    cpu_req,
    input wire logic [63:0] cpu_wdata,
    input wire logic [7:0]  cpu_wpar,
    input wire logic [63:0] bridge_rdata,
    // results
    input wire bus_sel_t    cpu_sel,
    input wire logic        dac_reject,
    input wire logic        boot_bank_select,
    input wire logic        remapped,
    input wire logic [7:0]  cpu_rpar,
    input wire logic        cpu_par_err
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // ==========================================================
    // helper logic
    // ==========================================================
    logic        go;     // a single address cycle request
    logic [31:0] a;      // requested address
    logic [7:0]  wp;     // even parity of incoming lanes
    logic [7:0]  rp;     // even parity of outgoing lanes
    always_comb begin
        go = cpu_req.valid && cpu_req.cmd != PCI_CMD_DAC;
        a  = cpu_req.addr;
        for (int i = 0; i < 8; i++) begin
            wp[i] = ^cpu_wdata[8*i+:8];
            rp[i] = ^bridge_rdata[8*i+:8];
        end
    end
    // ==========================================================
    // assertions
    // ==========================================================
    AST_IO: assert property (go && !remapped && a >= IO_BASE && a <= IO_LAST |=>
        cpu_sel.valid && cpu_sel.target == TGT_PCI_IO && cpu_sel.addr == $past(a) - IO_BASE)
        else $error("io window route wrong");
    AST_MEMC: assert property (go && a >= MEMC_BASE && a <= MEMC_LAST |=>
        cpu_sel.valid && cpu_sel.target == TGT_MEMC && cpu_sel.addr == $past(a))
        else $error("memory controller route wrong");
    AST_BRIDGE: assert property (go && a >= BRIDGE_BASE && a <= BRIDGE_LAST |=>
        cpu_sel.valid && cpu_sel.target == TGT_BRIDGE && cpu_sel.addr == $past(a))
        else $error("bridge route wrong");
    AST_ROM_A: assert property (go && a >= ROM_BASE && !boot_bank_select |=>
        cpu_sel.target == TGT_ROM_A && cpu_sel.addr == ($past(a) & ROM_OFF_MASK))
        else $error("soldered bank route wrong");
    AST_ROM_B: assert property (go && a >= ROM_BASE && boot_bank_select |=>
        cpu_sel.valid && cpu_sel.target == TGT_ROM_B)
        else $error("socketed bank route wrong");
    AST_LOW: assert property (go && !remapped && a < IO_BASE |=>
        !cpu_sel.valid && cpu_sel.target == TGT_NONE)
        else $error("low range selected a target");
    AST_HOLE: assert property (go && !remapped && a >= 32'hff00_0000 && a < ROM_BASE
        |=> !cpu_sel.valid && cpu_sel.target == TGT_NONE)
        else $error("hole selected a target");
    AST_DAC: assert property (cpu_req.valid && cpu_req.cmd == PCI_CMD_DAC |=>
        dac_reject && !cpu_sel.valid)
        else $error("dual address cycle not refused");
    AST_NO_DAC: assert property (!cpu_req.valid || go |=> !dac_reject)
        else $error("refusal without cause");
    AST_PERR: assert property (cpu_req.valid |=> cpu_par_err == $past(wp != cpu_wpar))
        else $error("parity check wrong");
    AST_RPAR: assert property (1'b1 |=> cpu_rpar == $past(rp))
        else $error("parity generation wrong");
    AST_RST: assert property ($fell(rst) |-> !remapped && !boot_bank_select && !cpu_sel.valid)
        else $error("reset state not default");
    // main scenarios reached
    cover property (go && a >= ROM_BASE && boot_bank_select);
    cover property (dac_reject);
    cover property (cpu_par_err);
    cover property (remapped && cpu_sel.target == TGT_PCI);
endmodule
bind default_addr_decoder default_addr_decoder_properties default_addr_decoder_properties_inst (
    .clk, .rst, .cpu_req, .cpu_wdata, .cpu_wpar, .bridge_rdata, .cpu_sel,
    .dac_reject, .boot_bank_select, .remapped, .cpu_rpar, .cpu_par_err);

// >>> tb/default_addr_decoder_tb_top.sv
// testbench: default map, bank select, remap and parity against a model
`timescale 1ns/1ps
module default_addr_decoder_tb_top;
    import addr_decode_pkg::*;
    typedef struct packed {bus_sel_t s; bus_sel_t p; logic d; logic e; logic [7:0] r;} exp_t;
    localparam logic [31:0] W_BASE = 32'hfef0_0000;  // window over a gap and memc
    localparam logic [31:0] W_LAST = 32'hfef8_ffff;
    localparam logic [31:0] W_OFF  = 32'h0000_1000;
    localparam logic [31:0] I_BASE = 32'h0001_0000;  // inbound window over low and i/o
    localparam logic [31:0] I_LAST = 32'h8001_ffff;
    localparam logic [31:0] I_OFF  = 32'h2000_0000;
    logic        clk, rst, cfg_we, cfg_remap, cfg_bank_wr, cfg_bank_val;
    map_win_t    cfg_win;
    logic [1:0]  cfg_dir, cfg_idx;
    bus_req_t    cpu_req, pci_req;
    logic [63:0] cpu_wdata, bridge_rdata;
    logic [7:0]  cpu_wpar, cpu_rpar;
    bus_sel_t    cpu_sel, pci_sel;
    logic        dac_reject, boot_bank_select, remapped, cpu_par_err;
    int          err_total, checks, seed, rb, rm;
    exp_t        q[$];
    logic [31:0] tbl [18] = '{32'h0, 32'h7fff_ffff, IO_BASE, IO_LAST, 32'h8002_0000,
        32'hfef0_0000, 32'hfef7_ffff, MEMC_BASE, MEMC_LAST, 32'hfef9_0000, 32'hfefe_ffff,
        BRIDGE_BASE, BRIDGE_LAST, 32'hff00_0000, 32'hffef_ffff, ROM_BASE, 32'hfff4_5678, ROM_LAST};
    default_addr_decoder default_addr_decoder_inst (.clk(clk), .rst(rst), .cfg_we(cfg_we),
        .cfg_dir(cfg_dir), .cfg_idx(cfg_idx), .cfg_win(cfg_win), .cfg_remap(cfg_remap),
        .cfg_bank_wr(cfg_bank_wr), .cfg_bank_val(cfg_bank_val), .cpu_req(cpu_req),
        .pci_req(pci_req), .cpu_wdata(cpu_wdata), .cpu_wpar(cpu_wpar),
        .bridge_rdata(bridge_rdata), .cpu_sel(cpu_sel), .pci_sel(pci_sel),
        .dac_reject(dac_reject), .boot_bank_select(boot_bank_select), .remapped(remapped),
        .cpu_rpar(cpu_rpar), .cpu_par_err(cpu_par_err));
    cpu_master cpu_master_inst (.clk(clk), .req(cpu_req), .wdata(cpu_wdata), .wpar(cpu_wpar));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // ==========================================================
    // model and comparisons
    // ==========================================================
    // priority memc, bridge, rom, then i/o or the window
    function automatic bus_sel_t ref_sel(input logic [31:0] a, input logic [1:0] c);
        ref_sel = '0;
        if (c == PCI_CMD_DAC)
            return ref_sel;
        if (a >= MEMC_BASE && a <= MEMC_LAST)
            ref_sel = {1'b1, TGT_MEMC, a};
        else if (a >= BRIDGE_BASE && a <= BRIDGE_LAST)
            ref_sel = {1'b1, TGT_BRIDGE, a};
        else if (a >= ROM_BASE)
            ref_sel = {1'b1, (rb != 0) ? TGT_ROM_B : TGT_ROM_A, a & ROM_OFF_MASK};
        else if (rm == 0 && a >= IO_BASE && a <= IO_LAST)
            ref_sel = {1'b1, TGT_PCI_IO, a - IO_BASE};
        else if (rm != 0 && a >= W_BASE && a <= W_LAST)
            ref_sel = {1'b1, TGT_PCI, a + W_OFF};
    endfunction
    // inbound decode: nothing from pci until remap, then the one window
    function automatic bus_sel_t ref_pci(input logic [31:0] a, input logic [1:0] c);
        ref_pci = '0;
        if (c != PCI_CMD_DAC && rm != 0 && a >= I_BASE && a <= I_LAST)
            ref_pci = {1'b1, TGT_CPU, a + I_OFF};
    endfunction
    function automatic logic [7:0] par(input logic [63:0] d);
        for (int i = 0; i < 8; i++)
            par[i] = ^d[8*i+:8];
    endfunction
    // address matters only when a target is selected
    task automatic chk_sel(input string n, input bus_sel_t e, input bus_sel_t g);
        checks++;
        if (e.valid ? (g !== e) : ({g.valid, g.target} !== {1'b0, TGT_NONE})) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk_val(input string n, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic cmp_out(input exp_t e);
        chk_sel("cpu_sel", e.s, cpu_sel);
        chk_sel("pci_sel", e.p, pci_sel);
        chk_val("dac_reject", 8'(e.d), 8'(dac_reject));
        chk_val("cpu_par_err", 8'(e.e), 8'(cpu_par_err));
        chk_val("cpu_rpar", e.r, cpu_rpar);
    endtask
    // ==========================================================
    // stimulus
    // ==========================================================
    // back to back: result of the previous request checked each cycle
    task automatic step(input logic [31:0] a, input logic [1:0] c, input logic bad);
        exp_t e;
        cpu_master_inst.issue(a, c, {$random(seed), $random(seed)}, bad);
        pci_req = {1'b1, a, c};
        bridge_rdata = {$random(seed), $random(seed)};
        if (q.size() > 0)
            cmp_out(q.pop_front());
        e = {ref_sel(a, c), ref_pci(a, c), c == PCI_CMD_DAC, bad, par(bridge_rdata)};
        q.push_back(e);
    endtask
    task automatic flush();
        cpu_master_inst.idle();
        pci_req.valid = 1'b0;
        cmp_out(q.pop_front());
    endtask
    task automatic give_verdict();
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial begin
        {cfg_we, cfg_remap, cfg_bank_wr, cfg_bank_val} = 4'h0;
        {cfg_dir, cfg_idx} = 4'h0;
        cfg_win = '0;
        pci_req = '0;
        bridge_rdata = '0;
        {err_total, checks, rb, rm} = '0;
        seed = 32'hd50274c1;
        rst = 1'b1;
        repeat (20) @(negedge clk);
        rst = 1'b0;
        chk_val("remapped", 8'h0, 8'(remapped));
        for (int p = 0; p < 3; p++) begin
            @(negedge clk);
            cfg_bank_wr = (p == 1);
            cfg_bank_val = 1'b1;
            // inbound window at index 3 first, outbound at index 0 with the remap
            cfg_we = (p != 0);
            cfg_remap = (p == 2);
            cfg_dir = (p == 1) ? DIR_PCI2CPU : DIR_CPU2PCI;
            cfg_idx = (p == 1) ? 2'h3 : 2'h0;
            cfg_win = (p == 1) ? {1'b1, I_BASE, I_LAST, I_OFF} : {1'b1, W_BASE, W_LAST, W_OFF};
            @(negedge clk);
            {cfg_we, cfg_remap, cfg_bank_wr} = 3'h0;
            rb = (p > 0);
            rm = (p == 2);
            chk_val("bank", 8'(rb), 8'(boot_bank_select));
            chk_val("remapped", 8'(rm), 8'(remapped));
            foreach (tbl[i]) step(tbl[i], 2'h0, 1'b0);
            step(ROM_BASE, PCI_CMD_DAC, 1'b1);
            repeat (25) step({tbl[$unsigned($random(seed)) % 18][31:16], 16'($random(seed))},
                2'($random(seed)), 1'($random(seed)));
            flush();
        end
        // mid-run reset must drop remap, windows and bank select
        @(negedge clk);
        rst = 1'b1;
        @(negedge clk);
        rst = 1'b0;
        {rb, rm} = '0;
        chk_val("bank", 8'h0, 8'(boot_bank_select));
        chk_val("remapped", 8'h0, 8'(remapped));
        foreach (tbl[i]) step(tbl[i], 2'h0, 1'b0);
        flush();
        give_verdict();
    end
    // hang guard far beyond the 182 cycles used
    initial begin
        #200000;
        err_total++;
        give_verdict();
    end
endmodule

// >>> verilog/data_parity.sv
// module: even byte parity generation and check for the processor data bus
`timescale 1ns/1ps
module data_parity
    import addr_decode_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // outgoing data
    input  wire logic [63:0] tx_data,
    output logic      [7:0]  tx_par,
    // incoming data with its parity
    input  wire logic        rx_valid,
    input  wire logic [63:0] rx_data,
    input  wire logic [7:0]  rx_par,
    output logic             par_err
);

    // parity of one byte lane, used on both paths
    function automatic logic lane_par(input logic [63:0] d, input int i);
        lane_par = ^d[i*8 +: 8];
    endfunction

    logic [7:0] next_tx_par;   // generated lanes
    logic [7:0] bad_lane;      // per lane mismatch
    logic       next_par_err;

    // ==========================================================
    // per lane generation and compare
    // ==========================================================
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_lane
            assign next_tx_par[g] = lane_par(tx_data, g);
            assign bad_lane[g]    = rx_valid & (lane_par(rx_data, g) != rx_par[g]);
        end
    endgenerate

    // error is flagged for one cycle per bad beat
    always_comb begin
        next_par_err = |bad_lane;
    end

    // register outputs
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            tx_par  <= 8'h00;
            par_err <= 1'b0;
        end else begin
            tx_par  <= next_tx_par;
            par_err <= next_par_err;
        end
    end

endmodule

// >>> verilog/default_addr_decoder.sv
// module: processor address decoder with default map and programmable windows
//
// Operation
// - reset restores default map until reprogrammed
// - map adjustable through programmable decoder windows
// - 80000000-8001FFFF goes to pci/isa i/o
// - FEF80000-FEF8FFFF selects memory controller registers
// - FEFF0000 64KB selects bridge registers
// - top 1MB goes to a boot bank
// - bank select clear: soldered flash first 1MB
// - bank select set: socketed rom bank
// - lowest 2GB selects no target
// - 15MB hole and gaps select nothing
// - four decoders in each direction
// - dual address cycles refused, single only
// - processor bus 66MHz, pci 33MHz max
// - data parity generated and checked
`timescale 1ns/1ps
module default_addr_decoder
    import addr_decode_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // window programming port
    input  wire logic        cfg_we,
    input  wire logic [1:0]  cfg_dir,
    input  wire logic [1:0]  cfg_idx,
    input  wire map_win_t    cfg_win,
    input  wire logic        cfg_remap,       // leave default map when set
    input  wire logic        cfg_bank_wr,
    input  wire logic        cfg_bank_val,
    // processor side request
    input  wire bus_req_t    cpu_req,
    // pci side request
    input  wire bus_req_t    pci_req,
    // processor data bus
    input  wire logic [63:0] cpu_wdata,
    input  wire logic [7:0]  cpu_wpar,
    input  wire logic [63:0] bridge_rdata,
    // decoded results
    output bus_sel_t         cpu_sel,
    output bus_sel_t         pci_sel,
    output logic             dac_reject,
    output logic             boot_bank_select,
    output logic             remapped,
    output logic [7:0]       cpu_rpar,
    output logic             cpu_par_err
);

    // ==========================================================
    // helpers
    // ==========================================================
    // inclusive range compare, used by every window
    function automatic logic in_range(input logic [31:0] a, input logic [31:0] lo,
                                      input logic [31:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction

    // ==========================================================
    // state
    // ==========================================================
    map_win_t   out_win  [NUM_WIN];     // processor to pci windows
    map_win_t   in_win   [NUM_WIN];     // pci to processor windows
    map_win_t   next_out_win [NUM_WIN];
    map_win_t   next_in_win  [NUM_WIN];
    logic       next_remapped;
    logic       next_bank;
    bus_sel_t   next_cpu_sel;
    bus_sel_t   next_pci_sel;
    logic       next_dac_reject;
    logic [NUM_WIN-1:0] out_hit;        // per window match, processor side
    logic [NUM_WIN-1:0] in_hit;         // per window match, pci side

    // ==========================================================
    // window match vectors
    // ==========================================================
    // four decoders each way
    genvar g;
    generate
        for (g = 0; g < NUM_WIN; g++) begin : g_win
            assign out_hit[g] = out_win[g].enable
                                && in_range(cpu_req.addr, out_win[g].base, out_win[g].last);
            assign in_hit[g]  = in_win[g].enable
                                && in_range(pci_req.addr, in_win[g].base, in_win[g].last);
        end
    endgenerate

    // ==========================================================
    // configuration next state
    // ==========================================================
    // windows and mode bits are only changed by the programming port
    always_comb begin
        next_out_win  = out_win;
        next_in_win   = in_win;
        next_remapped = remapped | cfg_remap;
        next_bank     = boot_bank_select;
        if (cfg_we && cfg_dir == DIR_CPU2PCI) begin
            next_out_win[cfg_idx] = cfg_win;
        end else if (cfg_we && cfg_dir == DIR_PCI2CPU) begin
            next_in_win[cfg_idx] = cfg_win;
        end
        // bank select is a plain software bit
        if (cfg_bank_wr) begin
            next_bank = cfg_bank_val;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < NUM_WIN; i++) begin
                out_win[i] <= '0;
                in_win[i]  <= '0;
            end
            remapped         <= 1'b0;
            boot_bank_select <= 1'b0;
        end else begin
            out_win          <= next_out_win;
            in_win           <= next_in_win;
            remapped         <= next_remapped;
            boot_bank_select <= next_bank;
        end
    end

    // ==========================================================
    // processor side decode
    // ==========================================================
    // fixed windows are checked first, then programmable ones in index
    // order; the priority chain keeps exactly one target per address
    always_comb begin
        next_cpu_sel        = '0;
        next_cpu_sel.target = TGT_NONE;
        next_dac_reject     = 1'b0;
        if (cpu_req.valid) begin
            if (cpu_req.cmd == PCI_CMD_DAC) begin
                next_dac_reject = 1'b1;
            end else if (in_range(cpu_req.addr, MEMC_BASE, MEMC_LAST)) begin
                next_cpu_sel.valid  = 1'b1;
                next_cpu_sel.target = TGT_MEMC;
                next_cpu_sel.addr   = cpu_req.addr;
            end else if (in_range(cpu_req.addr, BRIDGE_BASE, BRIDGE_LAST)) begin
                next_cpu_sel.valid  = 1'b1;
                next_cpu_sel.target = TGT_BRIDGE;
                next_cpu_sel.addr   = cpu_req.addr;
            end else if (in_range(cpu_req.addr, ROM_BASE, ROM_LAST)) begin
                next_cpu_sel.valid  = 1'b1;
                next_cpu_sel.target = boot_bank_select ? TGT_ROM_B : TGT_ROM_A;
                next_cpu_sel.addr   = cpu_req.addr & ROM_OFF_MASK;
            end else if (!remapped && in_range(cpu_req.addr, IO_BASE, IO_LAST)) begin
                next_cpu_sel.valid  = 1'b1;
                next_cpu_sel.target = TGT_PCI_IO;
                next_cpu_sel.addr   = cpu_req.addr - IO_BASE;
            end else if (remapped && |out_hit) begin
                // lowest index wins where software overlaps windows
                for (int i = NUM_WIN - 1; i >= 0; i--) begin
                    if (out_hit[i]) begin
                        next_cpu_sel.valid  = 1'b1;
                        next_cpu_sel.target = TGT_PCI;
                        next_cpu_sel.addr   = cpu_req.addr + out_win[i].offset;
                    end
                end
            end
        end
    end

    // ==========================================================
    // pci side decode
    // ==========================================================
    // inbound windows only, default map maps nothing from pci
    always_comb begin
        next_pci_sel        = '0;
        next_pci_sel.target = TGT_NONE;
        if (pci_req.valid && pci_req.cmd != PCI_CMD_DAC && remapped) begin
            for (int i = NUM_WIN - 1; i >= 0; i--) begin
                if (in_hit[i]) begin
                    next_pci_sel.valid  = 1'b1;
                    next_pci_sel.target = TGT_CPU;
                    next_pci_sel.addr   = pci_req.addr + in_win[i].offset;
                end
            end
        end
    end

    // registered decode results, one cycle after request
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cpu_sel    <= '0;
            pci_sel    <= '0;
            dac_reject <= 1'b0;
        end else begin
            cpu_sel    <= next_cpu_sel;
            pci_sel    <= next_pci_sel;
            dac_reject <= next_dac_reject;
        end
    end

    // ==========================================================
    // data parity
    // ==========================================================
    // one clock, sized for 66MHz processor bus
    data_parity u_parity (
        .clk      (clk),
        .rst      (rst),
        .tx_data  (bridge_rdata),
        .tx_par   (cpu_rpar),
        .rx_valid (cpu_req.valid),
        .rx_data  (cpu_wdata),
        .rx_par   (cpu_wpar),
        .par_err  (cpu_par_err)
    );

endmodule
